// *** mcad_pkg.sv ***
// Behaviour
// RL1: Single-output check opcode, selector, on/off bit
// RL2: Selector codes map HS pairs, LS vds
// RL3: Checks change only on permitted outputs
// RL4: All checks disabled after reset
// RL5: Check operand 0 disables, 1 enables
// RL6: All-output check acts on permitted outputs
// RL7: Enabled fault condition raises error interrupt
// RL8: Shortcut check opcode with four 2-bit fields
// RL9: Field 00 keep, 10 off, 11 on
// RL10: Shortcut targets follow current shortcut mapping
// RL11: Return-config opcode with 2-bit operand
// RL12: Operand 00 ignore, 10 continue, 11 restart
// RL13: Return requests ignored after reset
// RL14: Driver re-enable issues return when selected
// RL15: Status access issues return after fault
// RL16: Software sets status clear-on-read first
package mcad_pkg;

  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam logic [10:0] OPC_SINGLE   = 11'h1A6;
  localparam logic [14:0] OPC_ALL      = 15'h1B00;
  localparam logic [7:0]  OPC_SHORTCUT = 8'h26;
  localparam logic [13:0] OPC_RETCFG   = 14'h0D81;

  localparam logic [1:0] FLD_KEEP = 2'h0;
  localparam logic [1:0] FLD_NA   = 2'h1;
  localparam logic [1:0] FLD_OFF  = 2'h2;
  localparam logic [1:0] FLD_ON   = 2'h3;

  typedef enum logic [1:0] {
    MCAD_RET_NONE     = 2'h0,
    MCAD_RET_CONTINUE = 2'h2,
    MCAD_RET_RESTART  = 2'h3
  } mcad_ret_t;

  // ---------------------------------------------------------------
  // Outputs: index 0..4 high side, 5..11 low side
  // ---------------------------------------------------------------
  localparam int          NUM_DRV    = 12;
  localparam int          NUM_HS     = 5;
  localparam logic [3:0]  SEL_LS_BASE = 4'hA;
  localparam logic [3:0]  LS_FIRST   = 4'h5;
  localparam logic [3:0]  SC_UNDEF   = 4'hC;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_PERM_A  = 10'h184;
  localparam logic [9:0] IDX_PERM_B  = 10'h185;
  localparam logic [9:0] IDX_PERM_C  = 10'h186;
  localparam logic [9:0] IDX_PERM_D  = 10'h187;
  localparam logic [9:0] IDX_SETUP   = 10'h1C5;
  localparam logic [9:0] IDX_FSTATE  = 10'h1D2;
  localparam logic [9:0] IDX_IRQ_ST  = 10'h1E0;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h1E1;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h1E2;
  localparam logic [9:0] IDX_CHK_ST  = 10'h1E3;

  localparam logic [15:0] PERM_RST  = 16'h0000;
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam int SETUP_RET_SRC = 0;
  localparam int SETUP_CLR_RD  = 1;
  localparam int FSTATE_SRC    = 12;

  localparam int NUM_IRQ  = 3;
  localparam int IRQ_DIAG = 0;
  localparam int IRQ_RET  = 1;
  localparam int IRQ_BAD  = 2;
  localparam int CHK_SRC_LSB = 12;

endpackage

// *** mcad_decode.sv ***
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mcad_decode (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  core_index,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [3:0]  shortcut1_map,
  input  wire logic [3:0]  shortcut2_map,
  input  wire logic [3:0]  shortcut3_map,
  input  wire logic [11:0] vds_fault_pin,
  input  wire logic [4:0]  src_fault_pin,
  input  wire logic        drivers_reenabled,
  output logic             instr_taken,
  output logic             diag_irq,
  output logic             ret_continue,
  output logic             ret_restart,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] sc_apply(input logic [11:0] vec,
                                           input logic [3:0]  tgt,
                                           input logic [1:0]  op,
                                           input logic [11:0] perm);
    logic [11:0] r;
    r = vec;
    if (tgt < mcad_pkg::SC_UNDEF && perm[tgt]) begin // RL3
      if (op == mcad_pkg::FLD_ON) begin // RL9
        r[tgt] = 1'b1;
      end else if (op == mcad_pkg::FLD_OFF) begin // RL9
        r[tgt] = 1'b0;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] word16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  function automatic logic [31:0] word_irq(input logic [mcad_pkg::NUM_IRQ-1:0] v);
    return {29'h0, v};
  endfunction

  // Driver index of a single-output selector code
  function automatic logic [3:0] sel_drv(input logic [3:0] sel);
    if (sel < mcad_pkg::SEL_LS_BASE) begin // RL2
      return {1'b0, sel[3:1]};
    end
    return sel - mcad_pkg::SEL_LS_BASE + mcad_pkg::LS_FIRST; // RL2
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [15:0] perm_q [4];
  logic [15:0] setup_q;
  logic [15:0] fstate_q;
  localparam int NUM_IRQ_W = mcad_pkg::NUM_IRQ;
  logic [NUM_IRQ_W-1:0] irq_st_q;
  logic [NUM_IRQ_W-1:0] irq_en_q;
  logic [11:0] vds_en_q;
  logic [11:0] vds_en_d;
  logic [4:0]  src_en_q;
  logic [4:0]  src_en_d;
  mcad_pkg::mcad_ret_t ret_mode_q;
  logic [16:0] fs1_q;
  logic [16:0] fs2_q;
  logic [16:0] fs3_q;
  logic [16:0] flt_q;
  logic        hit_q;
  logic        diag_pend_q;
  logic [11:0] perm;
  logic [9:0]  idx;
  logic        hit_single;
  logic        hit_all;
  logic        hit_sc;
  logic        hit_ret;
  logic        bad_op;
  logic        hit_now;
  logic        diag_evt;
  logic        wr_acc;
  logic        rd_acc;
  logic        fs_access;
  logic        ret_req;
  logic        ret_evt;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [3:0]  drv;
  logic [11:0] sc_src;
  logic [15:0] fstate_clr;

  assign perm = perm_q[core_index][11:0];
  assign idx  = paddr[11:2];

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  assign hit_single = instr_valid && instr_word[15:5] == mcad_pkg::OPC_SINGLE; // RL1
  assign hit_all    = instr_valid && instr_word[15:1] == mcad_pkg::OPC_ALL; // RL6
  assign hit_sc     = instr_valid && instr_word[15:8] == mcad_pkg::OPC_SHORTCUT; // RL8
  assign hit_ret    = instr_valid && instr_word[15:2] == mcad_pkg::OPC_RETCFG; // RL11
  assign bad_op = (hit_ret && instr_word[1:0] == mcad_pkg::FLD_NA) ||
                  (hit_sc && (instr_word[7:6] == mcad_pkg::FLD_NA ||
                              instr_word[5:4] == mcad_pkg::FLD_NA ||
                              instr_word[3:2] == mcad_pkg::FLD_NA ||
                              instr_word[1:0] == mcad_pkg::FLD_NA));

  always_comb begin
    vds_en_d = vds_en_q;
    src_en_d = src_en_q;
    drv      = 4'h0;
    sc_src   = 12'h000;
    if (hit_single) begin
      if (instr_word[4:1] < mcad_pkg::SEL_LS_BASE) begin // RL2
        drv = sel_drv(instr_word[4:1]);
        if (perm[drv]) begin // RL3
          if (instr_word[1]) begin
            src_en_d[drv[2:0]] = instr_word[0]; // RL5
          end else begin
            vds_en_d[drv] = instr_word[0]; // RL5
          end
        end
      end else begin
        drv = sel_drv(instr_word[4:1]); // RL2
        if (perm[drv]) begin // RL3
          vds_en_d[drv] = instr_word[0]; // RL5
        end
      end
    end else if (hit_all) begin
      if (instr_word[0]) begin // RL5
        vds_en_d = vds_en_q | perm; // RL6
        src_en_d = src_en_q | perm[4:0];
      end else begin
        vds_en_d = vds_en_q & ~perm; // RL6
        src_en_d = src_en_q & ~perm[4:0];
      end
    end else if (hit_sc) begin
      // Mapping is resolved once, at execution time
      vds_en_d = sc_apply(vds_en_d, shortcut1_map, instr_word[7:6], perm); // RL10
      vds_en_d = sc_apply(vds_en_d, shortcut2_map, instr_word[3:2], perm); // RL10
      vds_en_d = sc_apply(vds_en_d, shortcut3_map, instr_word[1:0], perm); // RL10
      if (shortcut1_map < mcad_pkg::LS_FIRST) begin
        sc_src   = sc_apply({7'h00, src_en_d}, shortcut1_map, instr_word[5:4], perm); // RL9
        src_en_d = sc_src[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Check enables and return mode
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vds_en_q <= 12'h000; // RL4
      src_en_q <= 5'h00; // RL4
    end else begin
      vds_en_q <= vds_en_d;
      src_en_q <= src_en_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_mode_q <= mcad_pkg::MCAD_RET_NONE; // RL13
    end else if (hit_ret && instr_word[1:0] != mcad_pkg::FLD_NA) begin
      ret_mode_q <= mcad_pkg::mcad_ret_t'(instr_word[1:0]); // RL12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_taken <= 1'b0;
    end else begin
      instr_taken <= hit_single | hit_all | hit_sc | hit_ret;
    end
  end

  // ---------------------------------------------------------------
  // Feedback filter: three stages, change when last two agree
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs1_q <= 17'h00000;
      fs2_q <= 17'h00000;
      fs3_q <= 17'h00000;
      flt_q <= 17'h00000;
    end else begin
      fs1_q <= {src_fault_pin, vds_fault_pin};
      fs2_q <= fs1_q;
      fs3_q <= fs2_q;
      flt_q <= (fs2_q & fs3_q) | (flt_q & (fs2_q | fs3_q));
    end
  end

  // Edge of the combined condition, so one fault fires once
  assign hit_now  = |(flt_q[11:0] & vds_en_q) | |(flt_q[16:12] & src_en_q);
  assign diag_evt = hit_now && !hit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q    <= 1'b0;
      diag_irq <= 1'b0;
    end else begin
      hit_q    <= hit_now;
      diag_irq <= diag_evt; // RL7
    end
  end

  // ---------------------------------------------------------------
  // APB access
  // ---------------------------------------------------------------
  assign wr_acc    = psel && penable && pready && pwrite;
  assign rd_acc    = psel && penable && pready && !pwrite;
  assign fs_access = (wr_acc || rd_acc) && idx == mcad_pkg::IDX_FSTATE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (idx)
      mcad_pkg::IDX_PERM_A:  rd_mux = word16(perm_q[0]);
      mcad_pkg::IDX_PERM_B:  rd_mux = word16(perm_q[1]);
      mcad_pkg::IDX_PERM_C:  rd_mux = word16(perm_q[2]);
      mcad_pkg::IDX_PERM_D:  rd_mux = word16(perm_q[3]);
      mcad_pkg::IDX_SETUP:   rd_mux = word16(setup_q);
      mcad_pkg::IDX_FSTATE:  rd_mux = word16(fstate_q);
      mcad_pkg::IDX_IRQ_ST:  rd_mux = word_irq(irq_st_q);
      mcad_pkg::IDX_IRQ_EN:  rd_mux = word_irq(irq_en_q);
      mcad_pkg::IDX_IRQ_CLR: rd_mux = 32'h0000_0000;
      mcad_pkg::IDX_CHK_ST:  rd_mux = {13'h0, ret_mode_q, src_en_q, vds_en_q};
      default:               rd_ok  = 1'b0;
    endcase
  end

  // Zero wait states; data and error are staged in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !rd_ok;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        perm_q[i] <= mcad_pkg::PERM_RST; // RL4
      end
      setup_q <= mcad_pkg::SETUP_RST;
    end else if (wr_acc) begin
      for (int i = 0; i < 4; i++) begin
        if (idx == mcad_pkg::IDX_PERM_A + 10'(i)) begin
          perm_q[i] <= pwdata[15:0];
        end
      end
      if (idx == mcad_pkg::IDX_SETUP) begin
        setup_q <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault state
  // ---------------------------------------------------------------
  // Read clear and write-one clear share one mask
  always_comb begin
    fstate_clr = 16'h0000;
    if (rd_acc && idx == mcad_pkg::IDX_FSTATE && setup_q[mcad_pkg::SETUP_CLR_RD]) begin
      fstate_clr = 16'hFFFF;
    end else if (wr_acc && idx == mcad_pkg::IDX_FSTATE) begin
      fstate_clr = pwdata[15:0];
    end
  end

  // Latched faults; a new fault wins over read clear or write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate_q <= 16'h0000;
    end else begin
      fstate_q <= (fstate_q & ~fstate_clr) |
                  {3'h0, |(flt_q[16:12] & src_en_q), flt_q[11:0] & vds_en_q};
    end
  end

  // ---------------------------------------------------------------
  // Automatic interrupt return
  // ---------------------------------------------------------------
  assign ret_req = setup_q[mcad_pkg::SETUP_RET_SRC] ? (fs_access && diag_pend_q) : // RL15
                                                      drivers_reenabled; // RL14
  assign ret_evt = ret_req && ret_mode_q != mcad_pkg::MCAD_RET_NONE; // RL12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_pend_q <= 1'b0;
    end else if (diag_evt) begin
      diag_pend_q <= 1'b1;
    end else if (fs_access) begin
      diag_pend_q <= 1'b0; // RL15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_continue <= 1'b0;
      ret_restart  <= 1'b0;
    end else begin
      ret_continue <= ret_evt && ret_mode_q == mcad_pkg::MCAD_RET_CONTINUE; // RL12
      ret_restart  <= ret_evt && ret_mode_q == mcad_pkg::MCAD_RET_RESTART; // RL12
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, enable and clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;
    end else if (wr_acc && idx == mcad_pkg::IDX_IRQ_EN) begin
      irq_en_q <= pwdata[NUM_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ_W; i++) begin
        if ((i == mcad_pkg::IRQ_DIAG && diag_evt) ||
            (i == mcad_pkg::IRQ_RET && ret_evt) ||
            (i == mcad_pkg::IRQ_BAD && bad_op)) begin
          irq_st_q[i] <= 1'b1;
        end else if (wr_acc && idx == mcad_pkg::IDX_IRQ_CLR && pwdata[i]) begin
          irq_st_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_q & irq_en_q);
    end
  end

endmodule
`default_nettype wire

// *** mcad_decode_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcad_decode_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        drivers_reenabled,
  input wire logic        instr_taken,
  input wire logic        diag_irq,
  input wire logic        ret_continue,
  input wire logic        ret_restart
);
  // ---------------------------------------------------------------
  // Decode and return checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_diag_once;
    diag_irq ##1 !diag_irq;
  endsequence
  sequence s_status_access;
    psel && penable && paddr[11:2] == mcad_pkg::IDX_FSTATE;
  endsequence
  chk_single_taken: assert property (
    instr_valid && instr_word[15:5] == mcad_pkg::OPC_SINGLE |=> instr_taken)
    else $error("single check word not taken");
  chk_all_taken: assert property (
    instr_valid && instr_word[15:1] == mcad_pkg::OPC_ALL |=> instr_taken)
    else $error("all output word not taken");
  chk_shortcut_taken: assert property (
    instr_valid && instr_word[15:8] == mcad_pkg::OPC_SHORTCUT |=> instr_taken)
    else $error("shortcut word not taken");
  chk_retcfg_taken: assert property (
    instr_valid && instr_word[15:2] == mcad_pkg::OPC_RETCFG |=> instr_taken)
    else $error("return config word not taken");
  chk_idle_quiet: assert property (!instr_valid |=> !instr_taken)
    else $error("taken without instruction");
  chk_diag_single: assert property (diag_irq |-> s_diag_once)
    else $error("diag pulse too long");
  chk_ret_onehot: assert property (!(ret_continue && ret_restart))
    else $error("both return modes at once");
  chk_ret_cause: assert property (
    (ret_continue || ret_restart) |->
      $past(drivers_reenabled) || $past(psel && penable && paddr[11:2] == mcad_pkg::IDX_FSTATE))
    else $error("return request without cause");
  cover property (s_status_access ##1 ret_restart);
endmodule
bind mcad_decode mcad_decode_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .drivers_reenabled(drivers_reenabled), .instr_taken(instr_taken),
  .diag_irq(diag_irq), .ret_continue(ret_continue), .ret_restart(ret_restart));
`default_nettype wire

// *** mcad_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcad_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [15:0] go_word,
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  // ---------------------------------------------------------------
  // Sequencer: one pulse per word
  // ---------------------------------------------------------------
  // Word scrambled between pulses so a stale value never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_valid <= 1'b0;
      instr_word  <= 16'h0000;
    end else begin
      instr_valid <= go;
      instr_word  <= go ? go_word : ~instr_word;
    end
  end
endmodule
`default_nettype wire

// *** test_mcad_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_mcad_decode;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, go = 0, instr_valid, dr = 0;
  logic [1:0]  core_index = 0;
  logic [15:0] go_word = 0, instr_word;
  logic [3:0]  map1 = 4'h0, map2 = 4'h5, map3 = 4'hB;
  logic [11:0] vds = 0;
  logic [4:0]  srcf = 5'h00;
  logic        taken, diag_irq, ret_continue, ret_restart, irq;
  int          failures = 0, n_compared = 0, cyc = 0, n_diag = 0, n_cont = 0, n_rst = 0;
  always #2.5 pclk = ~pclk;
  mcad_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .go_word(go_word),
    .instr_valid(instr_valid), .instr_word(instr_word));
  mcad_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_index(core_index), .instr_valid(instr_valid),
    .instr_word(instr_word), .shortcut1_map(map1), .shortcut2_map(map2),
    .shortcut3_map(map3), .vds_fault_pin(vds), .src_fault_pin(srcf),
    .drivers_reenabled(dr), .instr_taken(taken), .diag_irq(diag_irq),
    .ret_continue(ret_continue), .ret_restart(ret_restart), .irq(irq));
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (diag_irq === 1'b1) n_diag++;
    if (ret_continue === 1'b1) n_cont++;
    if (ret_restart === 1'b1) n_rst++;
    if (cyc == 4000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic exec(input logic [15:0] w);
    @(posedge pclk); go <= 1'b1; go_word <= w;
    @(posedge pclk); go <= 1'b0;
    repeat (2) @(posedge pclk);
    check(taken, 1'b1);
    @(posedge pclk);
  endtask
  task automatic state(input logic [31:0] exp);
    apb(1'b0, mcad_pkg::IDX_CHK_ST, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse_reenable();
    @(posedge pclk); dr <= 1'b1;
    @(posedge pclk); dr <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset();
    state(32'h0);
    apb(1'b0, mcad_pkg::IDX_PERM_A, 32'h0);
    check(rd, {16'h0000, mcad_pkg::PERM_RST});
    apb(1'b0, mcad_pkg::IDX_SETUP, 32'h0);
    check(rd, {16'h0000, mcad_pkg::SETUP_RST});
    apb(1'b0, 10'h000, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
  endtask
  task automatic t_single();
    apb(1'b1, mcad_pkg::IDX_PERM_A, 32'h10);
    exec(16'h34D3); exec(16'h34D1); exec(16'h34D5);
    state(32'h10010);
    exec(16'h34D2);
    state(32'h00010);
  endtask
  task automatic t_all();
    apb(1'b1, mcad_pkg::IDX_PERM_A, 32'h21);
    exec(16'h3601);
    state(32'h01031);
    exec(16'h3600);
    state(32'h00010);
    core_index <= 2'h1;
    exec(16'h3601);
    state(32'h00010);
    core_index <= 2'h0;
  endtask
  task automatic t_shortcut();
    apb(1'b1, mcad_pkg::IDX_PERM_A, 32'hFFF);
    exec(16'h26FE);
    state(32'h01031);
    exec(16'h2680);
    state(32'h01030);
    map2 <= 4'h6;
    exec(16'h260C); exec(16'h2640);
    state(32'h01070);
  endtask
  task automatic t_fault();
    apb(1'b1, mcad_pkg::IDX_IRQ_EN, 32'h0);
    vds <= 12'h100;
    repeat (10) @(posedge pclk);
    check(n_diag, 0);
    vds <= 12'h120;
    repeat (10) @(posedge pclk);
    check(n_diag, 1);
    check(irq, 1'b0);
    apb(1'b1, mcad_pkg::IDX_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    vds <= 12'h000;
    apb(1'b1, mcad_pkg::IDX_IRQ_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    srcf <= 5'h01;
    repeat (10) @(posedge pclk);
    check(n_diag, 2);
    srcf <= 5'h00;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_ret();
    pulse_reenable();
    check(n_cont, 0);
    exec(16'h3606);
    state(32'h41070);
    pulse_reenable();
    check(n_cont, 1);
    exec(16'h3605);
    state(32'h41070);
    exec(16'h3607);
    apb(1'b1, mcad_pkg::IDX_SETUP, 32'h3);
    vds <= 12'h020;
    repeat (10) @(posedge pclk);
    vds <= 12'h000;
    repeat (6) @(posedge pclk);
    check(n_diag, 3);
    apb(1'b0, mcad_pkg::IDX_FSTATE, 32'h0);
    check(rd, 32'h1020);
    repeat (2) @(posedge pclk);
    check(n_rst, 1);
    check(n_cont, 1);
    pulse_reenable();
    check(n_rst, 1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_single();
    t_all();
    t_shortcut();
    t_fault();
    t_ret();
    stop_test();
  end
endmodule
`default_nettype wire
